// ===== logic/i2c_wait_ctrl.sv
/*
 * Two-wire bus controller core: byte engine, interrupt and wait
 * control, address matching, extension codes, master clocking.
 * Assumes open-drain pads outside and an Avalon-MM master.
 */
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_wait_params.svh"
module i2c_wait_ctrl #(
	parameter int HALF_CYC = `HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic bus_event_irq
);
	import i2c_wait_pkg::*;

	// ====================================================
	// pin synchronisers and bus condition detection
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	logic scl_rise, scl_fall, start_det, stop_det;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_p <= sda_s;
			scl_out <= 1'b0; // open drain: pad only ever pulls low
			sda_out <= 1'b0;
		end
	end

	// edges are judged between the second and third stages
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_det = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_det = scl_s & scl_p & ~sda_p & sda_s;

	// ====================================================
	// register bus slave
	logic ace_reg, wtim_reg, spie_reg;
	logic [7:0] own_reg, shift_reg;
	logic msts_reg, ald_reg, exc_reg, coi_reg;
	logic trc_reg, ackd_reg, std_reg, spd_reg;
	logic [7:0] status;
	logic wr_take, wr_ctrl, wr_data, rd_stat;
	logic stt_p, spt_p, wrel_p, lrel_p;

	assign status = {msts_reg, ald_reg, exc_reg, coi_reg,
		trc_reg, ackd_reg, std_reg, spd_reg};
	assign wr_take = avs_write & ~avs_waitrequest & avs_byteenable[0];
	assign wr_ctrl = wr_take & (avs_address == `OFS_CTRL);
	assign wr_data = wr_take & (avs_address == `OFS_DATA);
	assign rd_stat = avs_read & ~avs_waitrequest & (avs_address == `OFS_STAT);
	assign stt_p = wr_ctrl & avs_writedata[`CTL_STT];
	assign spt_p = wr_ctrl & avs_writedata[`CTL_SPT];
	assign wrel_p = wr_ctrl & avs_writedata[`CTL_WREL];
	assign lrel_p = wr_ctrl & avs_writedata[`CTL_LREL];

	// one wait state per access; data and effects land on the low cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if (avs_read & avs_waitrequest) begin
				unique case (avs_address)
					`OFS_CTRL: avs_readdata <= {27'h0, spie_reg, wtim_reg, ace_reg, 2'h0};
					`OFS_STAT: avs_readdata <= {24'h0, status};
					`OFS_DATA: avs_readdata <= {24'h0, shift_reg};
					`OFS_OWN: avs_readdata <= {24'h0, own_reg};
					default: avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// persistent control bits; action bits are pulses and read as zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ace_reg <= 1'b0;
			wtim_reg <= 1'b0;
			spie_reg <= 1'b0;
			own_reg <= `RST_BYTE;
		end else begin
			if (wr_ctrl) begin
				ace_reg <= avs_writedata[`CTL_ACE];
				wtim_reg <= avs_writedata[`CTL_WTIM];
				spie_reg <= avs_writedata[`CTL_SPIE];
			end
			if (wr_take && avs_address == `OFS_OWN) begin
				own_reg <= avs_writedata[7:0]; // only software changes it
			end
		end
	end

	// ====================================================
	// byte engine, status flags, interrupt and wait
	phase_t phase_reg;
	mstate_t m_state;
	logic [3:0] cnt_reg;
	logic wait_reg, active_reg, restart_reg, busy_reg, w8_reg;
	logic addr_ext, addr_match, m_gen, lose;

	// upper nibble 0000 covers general call, start byte, cbus and
	// reserved formats; 1111 0xx is the ten-bit prefix
	assign addr_ext = (shift_reg[7:4] == 4'h0) | (shift_reg[7:4] == 4'hf);
	assign addr_match = shift_reg[7:1] == own_reg[7:1];
	assign m_gen = (m_state == M_START);
	// master reads back a low where it released the line
	assign lose = scl_rise & msts_reg & trc_reg & (phase_reg != PH_IDLE)
		& (cnt_reg != 4'd8) & shift_reg[7] & ~sda_s;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			phase_reg <= PH_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= `RST_BYTE;
			wait_reg <= 1'b0;
			active_reg <= 1'b0;
			restart_reg <= 1'b0;
			w8_reg <= 1'b0;
			busy_reg <= 1'b0;
			msts_reg <= 1'b0;
			ald_reg <= 1'b0;
			exc_reg <= 1'b0;
			coi_reg <= 1'b0;
			trc_reg <= 1'b0;
			ackd_reg <= 1'b0;
			std_reg <= 1'b0;
			spd_reg <= 1'b0;
			bus_event_irq <= 1'b0;
		end else begin
			bus_event_irq <= 1'b0;
			// reading status clears the lost flag; a new loss below wins
			if (rd_stat) begin
				ald_reg <= 1'b0;
			end
			// master-only releases need the master flag
			if (wait_reg && (wr_data || wrel_p || (msts_reg && (stt_p || spt_p)))) begin
				wait_reg <= 1'b0;
			end
			if (wait_reg && wr_data) begin
				shift_reg <= avs_writedata[7:0];
			end
			if (wait_reg && wrel_p) begin
				trc_reg <= 1'b0; // release ends a transmission, stops echo drive
			end
			if (lrel_p) begin
				active_reg <= 1'b0; // drop out until next start
				wait_reg <= 1'b0;
				trc_reg <= 1'b0;
				phase_reg <= PH_IDLE;
			end
			if (stop_det) begin
				// lost flag survives so a lost master reads 41h
				spd_reg <= 1'b1;
				msts_reg <= 1'b0;
				exc_reg <= 1'b0;
				coi_reg <= 1'b0;
				trc_reg <= 1'b0;
				ackd_reg <= 1'b0;
				std_reg <= 1'b0;
				busy_reg <= 1'b0;
				active_reg <= 1'b0;
				wait_reg <= 1'b0;
				phase_reg <= PH_IDLE;
				bus_event_irq <= spie_reg;
			end else if (start_det) begin
				std_reg <= 1'b1;
				spd_reg <= 1'b0;
				exc_reg <= 1'b0;
				coi_reg <= 1'b0;
				ackd_reg <= 1'b0;
				busy_reg <= 1'b1;
				msts_reg <= m_gen; // master flag leads the status byte
				trc_reg <= m_gen;
				wait_reg <= m_gen; // master waits for its address byte
				restart_reg <= active_reg & ~msts_reg;
				active_reg <= 1'b1; // listen to every address
				phase_reg <= PH_ADDR;
				cnt_reg <= 4'hf; // the start's own clock fall wraps it to 0
			end else begin
				if (scl_rise && phase_reg != PH_IDLE) begin
					if (cnt_reg == 4'd8) begin
						ackd_reg <= ~sda_s;
					end else begin
						shift_reg <= {shift_reg[6:0], sda_s}; // line level, not sent bit
					end
					if (lose) begin
						ald_reg <= 1'b1;
						msts_reg <= 1'b0;
						trc_reg <= 1'b0;
						active_reg <= (phase_reg == PH_ADDR);
					end
				end
				// interrupt and wait decisions here are taken on a serial clock fall
				if (scl_fall && phase_reg != PH_IDLE) begin
					cnt_reg <= (cnt_reg == 4'd9) ? 4'd1 : cnt_reg + 4'd1;
					if (cnt_reg == 4'd9) begin
						w8_reg <= 1'b0;
						std_reg <= 1'b0;
						ackd_reg <= 1'b0;
					end
					if (active_reg && cnt_reg == 4'd7) begin
						if (phase_reg == PH_ADDR) begin
							exc_reg <= addr_ext;
							coi_reg <= ~msts_reg & addr_match;
							// direction bit: 1 means master receives
							trc_reg <= msts_reg ? ~shift_reg[0]
								: ((addr_match | addr_ext) & shift_reg[0]);
							if (!msts_reg && addr_ext) begin
								bus_event_irq <= 1'b1;
								wait_reg <= 1'b1;
							end
						end else if (!wtim_reg) begin
							bus_event_irq <= 1'b1;
							wait_reg <= 1'b1;
							w8_reg <= 1'b1; // at most one wait per byte, even if timing changes
						end
					end
					if (active_reg && cnt_reg == 4'd8) begin
						if (phase_reg == PH_ADDR) begin
							phase_reg <= PH_DATA;
							if (msts_reg || (addr_match && !addr_ext)) begin
								bus_event_irq <= 1'b1;
								wait_reg <= 1'b1;
							end else if (!addr_ext) begin
								active_reg <= 1'b0;
								bus_event_irq <= restart_reg; // no wait
							end
						end else if (wtim_reg && !w8_reg) begin
							bus_event_irq <= 1'b1;
							wait_reg <= 1'b1;
						end
					end
				end
			end
		end
	end

	// ====================================================
	// master clock and condition generator
	logic [15:0] hcnt;
	logic tick, hold, m_own, m_scl_low, m_sda_low;

	assign tick = hcnt == 16'(HALF_CYC - 1);
	assign m_own = (m_state != M_IDLE) && (m_state != M_RUN);
	// a wait in the run state or a slave stretching the clock holds the half period count at zero
	assign hold = ((m_state == M_RUN) && wait_reg) || (!m_scl_low && !scl_s);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			m_state <= M_IDLE;
			m_scl_low <= 1'b0;
			m_sda_low <= 1'b0;
			hcnt <= 16'h0000;
		end else begin
			hcnt <= (tick || hold || m_state == M_IDLE) ? 16'h0000 : hcnt + 16'h0001;
			unique case (m_state)
				M_IDLE: begin
					// a start on a busy bus is dropped
					if (stt_p && !busy_reg) begin
						m_sda_low <= 1'b1;
						m_state <= M_START;
					end
				end
				M_START: begin
					if (tick) begin
						m_scl_low <= 1'b1;
						m_state <= M_RUN;
					end
				end
				M_RUN: begin
					if (lose || stop_det) begin
						m_scl_low <= 1'b0;
						m_state <= M_IDLE;
					end else if (wait_reg && msts_reg && spt_p) begin
						m_sda_low <= 1'b1;
						m_state <= M_SP1;
					end else if (wait_reg && msts_reg && stt_p) begin
						m_sda_low <= 1'b0;
						m_state <= M_RS1;
					end else if (tick) begin
						m_scl_low <= ~m_scl_low;
					end
				end
				M_RS1: begin
					if (tick) begin
						m_scl_low <= 1'b0;
						m_state <= M_RS2;
					end
				end
				M_RS2: begin
					if (tick) begin
						m_sda_low <= 1'b1;
						m_state <= M_START;
					end
				end
				M_SP1: begin
					if (tick) begin
						m_scl_low <= 1'b0;
						m_state <= M_SP2;
					end
				end
				M_SP2: begin
					if (tick) begin
						m_sda_low <= 1'b0;
						m_state <= M_IDLE;
					end
				end
			endcase
		end
	end

	// ====================================================
	// pad drive: clock held low in any wait
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			scl_oe <= m_scl_low | wait_reg;
			if (m_own) begin
				sda_oe <= m_sda_low;
			end else if (!active_reg || phase_reg == PH_IDLE) begin
				sda_oe <= 1'b0;
			end else if (cnt_reg == 4'd8) begin
				// own address is acknowledged whatever the enable
				sda_oe <= (phase_reg == PH_ADDR)
					? (~msts_reg & (addr_match | (addr_ext & ace_reg)))
					: (~trc_reg & ace_reg);
			end else if (trc_reg && (phase_reg == PH_DATA || msts_reg)) begin
				// keep low after start until the address is written
				sda_oe <= ((cnt_reg == 4'd0 || cnt_reg == 4'hf) && wait_reg) ? 1'b1 : ~shift_reg[7];
			end else begin
				sda_oe <= 1'b0;
			end
		end
	end
endmodule : i2c_wait_ctrl
`default_nettype wire

// ===== logic/i2c_wait_params.svh
/*
 * Constants of the two-wire bus wait and interrupt block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and 32-bit Avalon-MM byte addresses.
 */
// Behaviour
// - master address byte: irq and wait at ninth fall
// - data byte: eighth fall if timing 0, else ninth
// - slave own match: irq, wait, forced ack at ninth
// - slave extension code: irq at eighth fall
// - mismatch after restart: ninth irq, no wait
// - no match, no extension: no irq, no wait
// - irq and wait follow serial clock falling edges
// - data write, release, start, stop end the wait
// - stop detected: irq if enabled, status 01h
// - hardware compares address, irq on match or code
// - shift register captures real line while sending
// - upper nibble 0000/1111 sets code flag, eighth irq
// - ten-bit prefix sets code and match flags; code sets the match flag only if bits 7:1 equal own address
// - code keeps slave engaged until bus release bit
// - extension codes decoded by upper nibble and bits; code decodes the upper nibble only
// - master status 1000X110, then 1000X000/1000X100
// - master extension status 1010X110, then data values
// - arbitration lost by stop reads status 41h
// - eighth address bit: 0 master sends, 1 receives
`ifndef I2C_WAIT_PARAMS_SVH
`define I2C_WAIT_PARAMS_SVH
`define OFS_CTRL 5'h00
`define OFS_STAT 5'h04
`define OFS_DATA 5'h08
`define OFS_OWN 5'h0c
`define CTL_SPT 0
`define CTL_STT 1
`define CTL_ACE 2
`define CTL_WTIM 3
`define CTL_SPIE 4
`define CTL_WREL 5
`define CTL_LREL 6
`define RST_BYTE 8'h00
`define CLK_NS 10
`define T_HALF_NS 5000
`define HALF_CYC ((`T_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== logic/i2c_wait_pkg.sv
/*
 * Types of the two-wire bus wait and interrupt block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package i2c_wait_pkg;
	typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} phase_t;
	typedef enum logic [2:0] {M_IDLE, M_START, M_RUN, M_RS1, M_RS2, M_SP1, M_SP2} mstate_t;
endpackage : i2c_wait_pkg

// ===== tb/i2c_wait_chk.sv
/* checker: register handshake, interrupt pulses and wait holding at the ports
   assumes it is bound to i2c_wait_ctrl and sees only its ports */
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module i2c_wait_chk (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic bus_event_irq
);
	logic hold_reg, irq_d;
	// the clock hold follows the interrupt pulse by one cycle
	always_ff @(posedge clk_sys) begin
		irq_d <= !srst && bus_event_irq;
	end
	// a wait entered with an interrupt lasts until software writes; loose on purpose
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hold_reg <= 1'b0;
		end else if (avs_write && !avs_waitrequest) begin
			hold_reg <= 1'b0;
		end else if (irq_d && scl_oe) begin
			hold_reg <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	AST_RESET_QUIET: assert property ($fell(srst) |-> avs_waitrequest && !scl_oe && !bus_event_irq)
		else $error("outputs not at rest after reset");
	AST_IRQ_PULSE: assert property (bus_event_irq |=> !bus_event_irq)
		else $error("interrupt longer than one cycle");
	AST_IRQ_AT_FALL: assert property (bus_event_irq |->
		(!$past(scl_in, 2) && $past(scl_in, 5))
		|| (scl_in && $past(scl_in, 5) && $past(sda_in, 2) && !$past(sda_in, 5)))
		else $error("interrupt neither after a clock fall nor after a stop");
	AST_WAIT_HOLD: assert property (hold_reg |-> scl_oe)
		else $error("wait ended without a release");
	AST_REQ_ANSWER: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("access not answered after one wait");
	AST_REQ_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for two cycles");
	AST_RD_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_OD_LOW: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("open drain output data not low");
	cover property (bus_event_irq ##1 scl_oe);
	cover property (bus_event_irq && scl_in);
	cover property (hold_reg && avs_write && !avs_waitrequest);
endmodule : i2c_wait_chk
bind i2c_wait_ctrl i2c_wait_chk chk_u (.clk_sys(clk_sys), .srst(srst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe),
	.bus_event_irq(bus_event_irq));
`default_nettype wire

// ===== tb/far_master.sv
/* far-end bus master model on the two wires
   assumes pull-ups on both lines and a 125 ns link clock that idles high */
`timescale 1ns/1ps
`default_nettype none
// ==========
// far-end master
module far_master (
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl_line,
	output logic sda_line
);
	logic scl_pull = 1'b0;
	logic sda_pull = 1'b0;
	int falls = 0;
	// wired-and: a released line goes to the pull-up level
	assign scl_line = !(scl_pull || scl_oe);
	assign sda_line = !(sda_pull || sda_oe);
	// one clock pulse; waits while the block stretches the clock low
	task automatic pulse(output logic seen);
		int n;
		n = 0;
		#31 scl_pull = 1'b0;
		while (scl_line !== 1'b1 && n < 4000) begin
			#10 n++;
		end
		seen = sda_line;
		#62 scl_pull = 1'b1;
		falls++;
		#32;
	endtask : pulse
	task automatic start_cond();
		sda_pull = 1'b1;
		#62 scl_pull = 1'b1;
	endtask : start_cond
	// msb first, last address bit is the direction
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		falls = 0;
		for (int i = 7; i >= 0; i--) begin
			sda_pull = !b[i];
			pulse(s);
		end
		sda_pull = 1'b0;
		pulse(s);
		ack = !s;
	endtask : send_byte
	task automatic stop_cond();
		sda_pull = 1'b1;
		#31 scl_pull = 1'b0;
		#62 sda_pull = 1'b0;
		#62;
	endtask : stop_cond
endmodule : far_master
`default_nettype wire

// ===== tb/i2c_wait_ctrl_tb.sv
/* bench: own address match, foreign address, extension code
   assumes the far master model and the bound checker */
`timescale 1ns/1ps
`default_nettype none
`include "i2c_wait_params.svh"
// ==========
// bench top
module i2c_wait_ctrl_tb;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, scl_oe, sda_oe, bus_event_irq, scl_line, sda_line, ack;
	logic [31:0] q;
	logic [7:0] st;
	int mismatches = 0;
	int tests_run = 0;
	int irq_cnt = 0;
	int irq_fall = 0;
	initial forever #5 clk_sys = ~clk_sys;
	i2c_wait_ctrl #(.HALF_CYC(8)) dut_u (.clk_sys(clk_sys), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .scl_in(scl_line), .scl_out(), .scl_oe(scl_oe),
		.sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .bus_event_irq(bus_event_irq));
	far_master far_u (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line));
	// note which serial clock fall each interrupt follows
	always @(posedge clk_sys) if (bus_event_irq === 1'b1) begin
		irq_cnt <= irq_cnt + 1;
		irq_fall <= far_u.falls;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// request held until the edge where waitrequest is low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !wr;
		avs_write <= wr;
		// sampled at the rising edge, before that edge's updates land
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			$display("unexpected bus answer: expected 0 seen 1");
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	// byte from the far end; at its interrupt keep status, then write ctl
	task automatic byte_wait(input logic [7:0] b, input int fall, input logic [7:0] ctl);
		int c0;
		int n;
		c0 = irq_cnt;
		n = 0;
		fork
			far_u.send_byte(b, ack);
			begin
				while (irq_cnt == c0 && n < 3000) begin
					@(negedge clk_sys);
					n++;
				end
				if (n >= 3000) begin
					mismatches++;
				end
				check("irq fall", 32'(irq_fall), 32'(fall));
				bus(1'b0, `OFS_STAT, 8'h00); // master flag read at every irq
				st = q[7:0];
				bus(1'b1, `OFS_CTRL, ctl); // exactly one release per wait
			end
		join
	endtask : byte_wait
	// ctl values: 10 stop irq, 34 release+ack+stop irq, 3c same with ninth wait
	task automatic own_match();
		int c0;
		c0 = irq_cnt;
		bus(1'b0, 5'h10, 8'h00);
		check("unmapped read", q, 32'h0);
		bus(1'b1, `OFS_OWN, 8'ha0);
		bus(1'b1, `OFS_CTRL, 8'h10);
		bus(1'b0, `OFS_CTRL, 8'h00);
		check("ctrl read", q, 32'h10);
		far_u.start_cond();
		byte_wait(8'ha0, 9, 8'h34);
		check("addr ack", {31'h0, ack}, 32'h1);
		check("addr status", {27'h0, st[7:3]}, 32'h2);
		byte_wait(8'h5a, 8, 8'h3c);
		byte_wait(8'hc3, 9, 8'h34);
		bus(1'b0, `OFS_DATA, 8'h00);
		check("rx data", q, 32'hc3);
		far_u.stop_cond();
		repeat (20) @(negedge clk_sys);
		check("stop irq", 32'(irq_cnt - c0), 32'h4);
		bus(1'b0, `OFS_STAT, 8'h00);
		check("stop status", q, 32'h01);
	endtask : own_match
	// a foreign address gives no interrupt, no wait and no acknowledge
	task automatic foreign_addr();
		int c0;
		c0 = irq_cnt;
		bus(1'b1, `OFS_CTRL, 8'h00);
		far_u.start_cond();
		far_u.send_byte(8'h62, ack);
		far_u.stop_cond();
		repeat (20) @(negedge clk_sys);
		check("foreign ack", {31'h0, ack}, 32'h0);
		check("foreign irq", 32'(irq_cnt - c0), 32'h0);
	endtask : foreign_addr
	// general call: eighth-fall interrupt with the code flag set
	task automatic ext_code();
		int c0;
		c0 = irq_cnt;
		far_u.start_cond();
		byte_wait(8'h00, 8, 8'h24);
		check("ext status", {27'h0, st[7:3]}, 32'h4);
		check("ext ack", {31'h0, ack}, 32'h1);
		far_u.stop_cond();
		repeat (20) @(negedge clk_sys);
		check("ext irq", 32'(irq_cnt - c0), 32'h1);
	endtask : ext_code
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		own_match();
		foreign_addr();
		ext_code();
		give_verdict();
	end
	// watchdog well beyond the few microseconds the tests need
	initial begin
		#300000;
		mismatches++;
		give_verdict();
	end
endmodule : i2c_wait_ctrl_tb
`default_nettype wire
